// [logic/dtc_defs.svh]
// Purpose: Constants for the dual timer/counter block
// Assumes: Byte-wide special function register bus
// Notes: Offsets are bus addresses of the registers
`ifndef DTC_DEFS_SVH
`define DTC_DEFS_SVH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define DTC_ADDR_CTRL 8'h88
`define DTC_ADDR_MODE 8'h89
`define DTC_ADDR_T0LO 8'h8A
`define DTC_ADDR_T1LO 8'h8B
`define DTC_ADDR_T0HI 8'h8C
`define DTC_ADDR_T1HI 8'h8D
// ----------------------------------------------------------------
// Control register bit positions
// ----------------------------------------------------------------
`define DTC_CTL_TF1 7
`define DTC_CTL_TR1 6
`define DTC_CTL_TF0 5
`define DTC_CTL_TR0 4
`define DTC_CTL_IE1 3
`define DTC_CTL_IT1 2
`define DTC_CTL_IE0 1
`define DTC_CTL_IT0 0
// ----------------------------------------------------------------
// Mode register bit positions
// ----------------------------------------------------------------
`define DTC_MOD_TIMER1_PIN_QUALIFY 7
`define DTC_MOD_CT1 6
`define DTC_MOD_M1_HI 5
`define DTC_MOD_M1_LO 4
`define DTC_MOD_TIMER0_PIN_QUALIFY 3
`define DTC_MOD_CT0 2
`define DTC_MOD_M0_HI 1
`define DTC_MOD_M0_LO 0
// ----------------------------------------------------------------
// Reset values and widths
// ----------------------------------------------------------------
`define DTC_RST_CTRL 8'h00
`define DTC_RST_MODE 8'h00
`define DTC_RST_CNT 8'h00
`define DTC_PRESC_MSB 4
`endif

// [logic/dtc_pkg.sv]
// Purpose: Types for the dual timer/counter block
// Assumes: Included header supplies constants
// Notes: State is one packed struct
package dtc_pkg;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DTC_M13,
    DTC_M16,
    DTC_MRELOAD,
    DTC_MSPLIT
  } dtc_mode_t;

  typedef struct packed {
    logic [7:0] lo;
    logic [7:0] hi;
  } dtc_count_t;

  typedef struct packed {
    logic [1:0] cntIn;
    logic [1:0] irqPin;
  } dtc_pins_t;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] mode;
    dtc_count_t t0;
    dtc_count_t t1;
    dtc_pins_t sync1;
    dtc_pins_t sync2;
    dtc_pins_t prev;
    logic [7:0] rdata;
    logic [1:0] tickOvf;
  } dtc_state_t;
endpackage : dtc_pkg

// [logic/dtc_timer.sv]
// Purpose: Two 16-bit timer/counters with external interrupt flags
// Assumes: One core clock, one machine cycle per clock
// Notes: Registers reached over the byte-wide register port
//
// Behaviour
// [R1] Two 16-bit counts from byte registers
// [R2] Timer mode advances every machine cycle
// [R3] Counter mode counts sampled high-then-low
// [R4] Edge detection limits rate to half clock
// [R5] Source holds each level two cycles
// [R6] Timer 1 gate needs pin high
// [R7] Timer 1 select picks pin or clock
// [R8] Timer 1 modes: 13-bit or 16-bit
// [R9] Timer 1 modes: autoreload or stopped
// [R10] Timer 0 gate needs pin high
// [R11] Timer 0 select picks pin or clock
// [R12] Timer 0 modes: 13-bit or 16-bit
// [R13] Timer 0 mode two autoreloads low byte
// [R14] Timer 1 overflow flag set, cleared vectoring
// [R15] Timer 0 overflow flag set, cleared vectoring
// [R16] Run bits start and stop timers
// [R17] Interrupt 1 flag by edge or level
// [R18] Interrupt 0 flag by edge or level
// [R19] Level flags follow pin, not vector
// [R20] Trigger bits: set edge, clear level
// [R21] 13-bit overflow sets flag on rollover
// [R22] Reload copies high into low only
// [R23] Run bit does not clear counts
// [R24] Timer 0 split uses Timer 1 controls
// [R25] 16-bit count wraps and continues
// [R26] Gate pins sampled synchronously
`timescale 1ns/1ps
`include "dtc_defs.svh"
module dtc_timer
  import dtc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  input wire logic countInputA,
  input wire logic countInputB,
  input wire logic extIrqPinA,
  input wire logic extIrqPinB,
  input wire logic [3:0] vectorAck,
  output logic [3:0] irqReq,
  output logic [1:0] timerOvf
);
  // vectorAck: 0 ext irq0, 1 timer0, 2 ext irq1, 3 timer1

  dtc_state_t st_r;
  dtc_state_t st_nxt;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    dtc_mode_t m0;
    dtc_mode_t m1;
    logic [1:0] edgeCnt;
    logic [1:0] pinFall;
    logic en0;
    logic en1;
    logic inc0;
    logic inc1;
    logic incSplit;
    logic [1:0] setTf;
    logic [8:0] sum;
    logic [5:0] pre;
    m0 = dtc_mode_t'(st_r.mode[`DTC_MOD_M0_HI:`DTC_MOD_M0_LO]);
    m1 = dtc_mode_t'(st_r.mode[`DTC_MOD_M1_HI:`DTC_MOD_M1_LO]);
    edgeCnt = '0;
    pinFall = '0;
    en0 = 1'b0;
    en1 = 1'b0;
    inc0 = 1'b0;
    inc1 = 1'b0;
    incSplit = 1'b0;
    setTf = '0;
    sum = '0;
    pre = '0;
    st_nxt = st_r;
    // Two-stage pin synchronisers
    st_nxt.sync1 = {countInputB, countInputA, extIrqPinB, extIrqPinA}; // R26
    st_nxt.sync2 = st_r.sync1;
    st_nxt.prev = st_r.sync2;
    // Falling edges: high sample then low sample
    edgeCnt = st_r.prev.cntIn & ~st_r.sync2.cntIn; // R3 R4
    pinFall = st_r.prev.irqPin & ~st_r.sync2.irqPin;
    // Run and gate qualification
    en0 = st_r.ctrl[`DTC_CTL_TR0] & (~st_r.mode[`DTC_MOD_TIMER0_PIN_QUALIFY] |
      st_r.sync2.irqPin[0]); // R10 R16 R23
    en1 = st_r.ctrl[`DTC_CTL_TR1] & (~st_r.mode[`DTC_MOD_TIMER1_PIN_QUALIFY] |
      st_r.sync2.irqPin[1]); // R6 R16
    inc0 = en0 & (st_r.mode[`DTC_MOD_CT0] ? edgeCnt[0] : 1'b1); // R2 R11
    inc1 = en1 & (st_r.mode[`DTC_MOD_CT1] ? edgeCnt[1] : 1'b1); // R7
    // Timer 1 stopped in its mode 3 only; while timer 0 is split it counts but sets no flag
    if (m1 == DTC_MSPLIT) begin
      inc1 = 1'b0; // R9 R24
    end
    incSplit = (m0 == DTC_MSPLIT) & st_r.ctrl[`DTC_CTL_TR1]; // R24
    // Timer 0 counting
    if (inc0) begin
      case (m0)
        DTC_M13: begin
          pre = {1'b0, st_r.t0.lo[`DTC_PRESC_MSB:0]} + 6'h01; // R12 R21
          st_nxt.t0.lo = {st_r.t0.lo[7:5], pre[4:0]};
          if (pre[5]) begin
            sum = {1'b0, st_r.t0.hi} + 9'h001;
            st_nxt.t0.hi = sum[7:0];
            setTf[0] = sum[8]; // R21
          end
        end
        DTC_M16: begin
          sum = {1'b0, st_r.t0.lo} + 9'h001; // R12 R1
          st_nxt.t0.lo = sum[7:0];
          if (sum[8]) begin
            sum = {1'b0, st_r.t0.hi} + 9'h001;
            st_nxt.t0.hi = sum[7:0]; // R25
            setTf[0] = sum[8];
          end
        end
        DTC_MRELOAD: begin
          sum = {1'b0, st_r.t0.lo} + 9'h001; // R13
          st_nxt.t0.lo = sum[8] ? st_r.t0.hi : sum[7:0]; // R22
          setTf[0] = sum[8];
        end
        default: begin
          sum = {1'b0, st_r.t0.lo} + 9'h001; // R24
          st_nxt.t0.lo = sum[7:0];
          setTf[0] = sum[8];
        end
      endcase
    end
    // Timer 0 high byte as machine-cycle timer in split mode
    if (incSplit) begin
      sum = {1'b0, st_r.t0.hi} + 9'h001; // R24
      st_nxt.t0.hi = sum[7:0];
      setTf[1] = sum[8];
    end
    // Timer 1 counting
    if (inc1) begin
      case (m1)
        DTC_M13: begin
          pre = {1'b0, st_r.t1.lo[`DTC_PRESC_MSB:0]} + 6'h01; // R8 R21
          st_nxt.t1.lo = {st_r.t1.lo[7:5], pre[4:0]};
          if (pre[5]) begin
            sum = {1'b0, st_r.t1.hi} + 9'h001;
            st_nxt.t1.hi = sum[7:0];
            setTf[1] = setTf[1] | ((m0 != DTC_MSPLIT) & sum[8]); // R24
          end
        end
        DTC_M16: begin
          sum = {1'b0, st_r.t1.lo} + 9'h001; // R8 R25
          st_nxt.t1.lo = sum[7:0];
          if (sum[8]) begin
            sum = {1'b0, st_r.t1.hi} + 9'h001;
            st_nxt.t1.hi = sum[7:0];
            setTf[1] = setTf[1] | ((m0 != DTC_MSPLIT) & sum[8]);
          end
        end
        default: begin
          sum = {1'b0, st_r.t1.lo} + 9'h001; // R9
          st_nxt.t1.lo = sum[8] ? st_r.t1.hi : sum[7:0]; // R22
          setTf[1] = setTf[1] | ((m0 != DTC_MSPLIT) & sum[8]); // R24
        end
      endcase
    end
    st_nxt.tickOvf = setTf;
    // Register writes
    if (regWr) begin
      if (regAddr == `DTC_ADDR_CTRL) begin
        st_nxt.ctrl = regWdata;
      end else if (regAddr == `DTC_ADDR_MODE) begin
        st_nxt.mode = regWdata;
      end else if (regAddr == `DTC_ADDR_T0LO) begin
        st_nxt.t0.lo = regWdata;
      end else if (regAddr == `DTC_ADDR_T1LO) begin
        st_nxt.t1.lo = regWdata;
      end else if (regAddr == `DTC_ADDR_T0HI) begin
        st_nxt.t0.hi = regWdata;
      end else if (regAddr == `DTC_ADDR_T1HI) begin
        st_nxt.t1.hi = regWdata;
      end
    end
    // Overflow flags: vector clears, hardware set wins
    if (vectorAck[1]) begin
      st_nxt.ctrl[`DTC_CTL_TF0] = 1'b0; // R15
    end
    if (vectorAck[3]) begin
      st_nxt.ctrl[`DTC_CTL_TF1] = 1'b0; // R14
    end
    if (setTf[0]) begin
      st_nxt.ctrl[`DTC_CTL_TF0] = 1'b1; // R15
    end
    if (setTf[1]) begin
      st_nxt.ctrl[`DTC_CTL_TF1] = 1'b1; // R14
    end
    // External interrupt 0 flag
    if (st_r.ctrl[`DTC_CTL_IT0]) begin
      if (vectorAck[0]) begin
        st_nxt.ctrl[`DTC_CTL_IE0] = 1'b0; // R19
      end
      if (pinFall[0]) begin
        st_nxt.ctrl[`DTC_CTL_IE0] = 1'b1; // R18 R20
      end
    end else begin
      st_nxt.ctrl[`DTC_CTL_IE0] = ~st_r.sync2.irqPin[0]; // R18 R19 R20
    end
    // External interrupt 1 flag
    if (st_r.ctrl[`DTC_CTL_IT1]) begin
      if (vectorAck[2]) begin
        st_nxt.ctrl[`DTC_CTL_IE1] = 1'b0; // R19
      end
      if (pinFall[1]) begin
        st_nxt.ctrl[`DTC_CTL_IE1] = 1'b1; // R17 R20
      end
    end else begin
      st_nxt.ctrl[`DTC_CTL_IE1] = ~st_r.sync2.irqPin[1]; // R17 R19 R20
    end
    // Registered read data
    st_nxt.rdata = 8'h00;
    if (regRd) begin
      if (regAddr == `DTC_ADDR_CTRL) begin
        st_nxt.rdata = st_r.ctrl;
      end else if (regAddr == `DTC_ADDR_MODE) begin
        st_nxt.rdata = st_r.mode;
      end else if (regAddr == `DTC_ADDR_T0LO) begin
        st_nxt.rdata = st_r.t0.lo;
      end else if (regAddr == `DTC_ADDR_T1LO) begin
        st_nxt.rdata = st_r.t1.lo;
      end else if (regAddr == `DTC_ADDR_T0HI) begin
        st_nxt.rdata = st_r.t0.hi;
      end else if (regAddr == `DTC_ADDR_T1HI) begin
        st_nxt.rdata = st_r.t1.hi;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '0;
      st_r.ctrl <= `DTC_RST_CTRL;
      st_r.mode <= `DTC_RST_MODE;
      st_r.t0 <= {`DTC_RST_CNT, `DTC_RST_CNT};
      st_r.t1 <= {`DTC_RST_CNT, `DTC_RST_CNT};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign regRdata = st_r.rdata;
  assign irqReq = {st_r.ctrl[`DTC_CTL_TF1], st_r.ctrl[`DTC_CTL_IE1],
    st_r.ctrl[`DTC_CTL_TF0], st_r.ctrl[`DTC_CTL_IE0]};
  assign timerOvf = st_r.tickOvf;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_t0_timer_step: assert property (@(posedge clk) disable iff (rst)
    (!regWr && st_r.ctrl[4] && !st_r.mode[2] &&
     (!st_r.mode[3] || st_r.sync2.irqPin[0]) &&
     st_r.mode[1:0] == 2'b01 && st_r.t0.lo != 8'hFF) |=>
    st_r.t0.lo == $past(st_r.t0.lo) + 8'h01) // R2
    else $error("timer0 did not advance");
  a_run_off_hold: assert property (@(posedge clk) disable iff (rst)
    (!regWr && !st_r.ctrl[4] && st_r.mode[1:0] != 2'b11) |=>
    $stable(st_r.t0.lo)) // R16
    else $error("timer0 moved while stopped");
  a_reload_copy: assert property (@(posedge clk) disable iff (rst)
    (!regWr && st_r.mode[1:0] == 2'b10 && st_nxt.tickOvf[0]) |=>
    st_r.t0.lo == $past(st_r.t0.hi) && $stable(st_r.t0.hi)) // R22
    else $error("reload wrong");
  a_tf0_set: assert property (@(posedge clk) disable iff (rst)
    st_r.tickOvf[0] |-> st_r.ctrl[5]) // R15
    else $error("timer0 flag not set");
  a_tf1_set: assert property (@(posedge clk) disable iff (rst)
    st_r.tickOvf[1] |-> st_r.ctrl[7]) // R14
    else $error("timer1 flag not set");
  a_ie0_level: assert property (@(posedge clk) disable iff (rst)
    (!regWr && !st_r.ctrl[0]) |=>
    st_r.ctrl[1] == !$past(st_r.sync2.irqPin[0])) // R19
    else $error("level flag wrong");
  a_timer0_pin_qualify_block: assert property (@(posedge clk) disable iff (rst)
    (!regWr && st_r.mode[3] && !st_r.sync2.irqPin[0] &&
     st_r.mode[1:0] != 2'b11) |=> $stable(st_r.t0)) // R10
    else $error("gated timer0 moved");
  a_t1_mode3_hold: assert property (@(posedge clk) disable iff (rst)
    (!regWr && st_r.mode[5:4] == 2'b11) |=> $stable(st_r.t1)) // R9
    else $error("timer1 moved in mode 3");
  a_cnt_edge: assert property (@(posedge clk) disable iff (rst)
    (!regWr && st_r.ctrl[4] && !st_r.mode[3] && st_r.mode[2] &&
     st_r.mode[1:0] != 2'b11 && !(st_r.prev.cntIn[0] &&
     !st_r.sync2.cntIn[0])) |=> $stable(st_r.t0.lo)) // R3
    else $error("count without edge");
  c_t0_ovf: cover property (@(posedge clk) st_r.tickOvf[0]);
  c_t1_ovf: cover property (@(posedge clk) st_r.tickOvf[1]);
  c_ie1_edge: cover property (@(posedge clk)
    st_r.ctrl[2] && $rose(st_r.ctrl[3]));
endmodule : dtc_timer

// [tb/dtc_pin_src.sv]
// Purpose: External event source on a timer count pin
// Assumes: Driven from the bench clock, idle level high
// Notes: Each level is held two cycles
`timescale 1ns/1ps
module dtc_pin_src (
  input wire logic clk,
  output logic pin
);
  initial pin = 1'b1;

  // ------------------------------------------------------------
  // Falling edges on request
  // ------------------------------------------------------------
  // Levels held two full cycles so each is sampled
  task automatic pulses(input int n);
    repeat (n) begin
      @(negedge clk);
      pin = 1'b0;
      repeat (2) @(negedge clk);
      pin = 1'b1;
      repeat (2) @(negedge clk);
    end
  endtask : pulses
endmodule : dtc_pin_src

// [tb/dtc_timer_tb.sv]
// Purpose: Self-checking bench for the dual timer block
// Assumes: Inputs driven at the falling clock edge
// Notes: Random values from a fixed-seed xorshift
`timescale 1ns/1ps
`include "dtc_defs.svh"
`define CHK(nm, e, g) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) begin \
      $display("FAIL %s exp %h got %h", nm, e, g); \
      fail_count++; \
    end \
  end
module dtc_timer_tb;
  import dtc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regWdata = 8'h00;
  logic [7:0] regRdata;
  logic countInputA;
  logic countInputB;
  logic extIrqPinA = 1'b1;
  logic extIrqPinB = 1'b1;
  logic [3:0] vectorAck = 4'h0;
  logic [3:0] irqReq;
  logic [1:0] timerOvf;
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h4236_37f0;
  logic [7:0] d;
  int n;

  always #2 clk = ~clk;

  dtc_timer dut_u (.clk(clk), .rst(rst), .regAddr(regAddr), .regWr(regWr),
    .regRd(regRd), .regWdata(regWdata), .regRdata(regRdata),
    .countInputA(countInputA), .countInputB(countInputB),
    .extIrqPinA(extIrqPinA), .extIrqPinB(extIrqPinB),
    .vectorAck(vectorAck), .irqReq(irqReq), .timerOvf(timerOvf));
  dtc_pin_src src_u (.clk(clk), .pin(countInputA));
  dtc_pin_src src1_u (.clk(clk), .pin(countInputB));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    regAddr = a;
    regWdata = v;
    regWr = 1'b1;
    @(negedge clk);
    regWr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge clk);
    regAddr = a;
    regRd = 1'b1;
    @(negedge clk);
    regRd = 1'b0;
    v = regRdata;
  endtask : rd

  task automatic chkRd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    `CHK("register", e, v)
  endtask : chkRd

  // Bounded wait for an overflow pulse
  task automatic waitOvf(input int b);
    logic seen;
    seen = 1'b0;
    repeat (40) begin
      @(negedge clk);
      if (timerOvf[b] === 1'b1) seen = 1'b1;
      if (seen) break;
    end
    `CHK("overflow", 1'b1, seen)
  endtask : waitOvf

  task automatic ack(input int b);
    @(negedge clk);
    vectorAck[b] = 1'b1;
    @(negedge clk);
    vectorAck = 4'h0;
    @(negedge clk);
  endtask : ack

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop

  // Cycle ceiling against hangs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    chkRd(`DTC_ADDR_MODE, `DTC_RST_MODE);
    chkRd(8'h90, 8'h00);
    // Mode register read back with random values
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      wr(`DTC_ADDR_MODE, seed[7:0]);
      chkRd(`DTC_ADDR_MODE, seed[7:0]);
    end
    // Autoreload, flag set and cleared on vectoring
    wr(`DTC_ADDR_MODE, 8'h02);
    wr(`DTC_ADDR_T0HI, 8'h10);
    wr(`DTC_ADDR_T0LO, 8'hFE);
    wr(`DTC_ADDR_CTRL, 8'h11);
    waitOvf(0);
    `CHK("tf0", 1'b1, irqReq[1])
    chkRd(`DTC_ADDR_T0HI, 8'h10);
    ack(1);
    `CHK("tf0 clr", 1'b0, irqReq[1])
    // Thirteen-bit rollover
    wr(`DTC_ADDR_MODE, 8'h00);
    wr(`DTC_ADDR_T0HI, 8'hFF);
    wr(`DTC_ADDR_T0LO, 8'h1F);
    waitOvf(0);
    wr(`DTC_ADDR_CTRL, 8'h01);
    chkRd(`DTC_ADDR_T0HI, 8'h00);
    // Timer 1 sixteen-bit wrap, then mode 3 hold
    wr(`DTC_ADDR_MODE, 8'h10);
    wr(`DTC_ADDR_T1LO, 8'hF0);
    wr(`DTC_ADDR_T1HI, 8'hFF);
    wr(`DTC_ADDR_CTRL, 8'h41);
    waitOvf(1);
    `CHK("tf1", 1'b1, irqReq[3])
    chkRd(`DTC_ADDR_T1HI, 8'h00);
    ack(3);
    `CHK("tf1 clr", 1'b0, irqReq[3])
    wr(`DTC_ADDR_MODE, 8'h30);
    wr(`DTC_ADDR_T1LO, 8'h33);
    repeat (8) @(negedge clk);
    chkRd(`DTC_ADDR_T1LO, 8'h33);
    // Event counting of random edge counts
    wr(`DTC_ADDR_MODE, 8'h05);
    wr(`DTC_ADDR_T0LO, 8'h00);
    wr(`DTC_ADDR_T0HI, 8'h00);
    wr(`DTC_ADDR_CTRL, 8'h11);
    seed = xs(seed);
    n = 1 + int'(seed[3:0]);
    src_u.pulses(n);
    repeat (6) @(negedge clk);
    wr(`DTC_ADDR_CTRL, 8'h01);
    chkRd(`DTC_ADDR_T0LO, 8'(n));
    wr(`DTC_ADDR_CTRL, 8'h11);
    src_u.pulses(1);
    repeat (6) @(negedge clk);
    wr(`DTC_ADDR_CTRL, 8'h01);
    chkRd(`DTC_ADDR_T0LO, 8'(n + 1));
    // Gate held low stops counting, high lets it run
    wr(`DTC_ADDR_MODE, 8'h09);
    wr(`DTC_ADDR_T0LO, 8'h00);
    extIrqPinA = 1'b0;
    wr(`DTC_ADDR_CTRL, 8'h11);
    repeat (8) @(negedge clk);
    wr(`DTC_ADDR_CTRL, 8'h01);
    chkRd(`DTC_ADDR_T0LO, 8'h00);
    extIrqPinA = 1'b1;
    wr(`DTC_ADDR_CTRL, 8'h11);
    repeat (8) @(negedge clk);
    wr(`DTC_ADDR_CTRL, 8'h01);
    rd(`DTC_ADDR_T0LO, d);
    `CHK("gated run", 1'b1, d != 8'h00)
    // Timer 0 split: high byte runs on timer 1 controls
    wr(`DTC_ADDR_MODE, 8'h23);
    wr(`DTC_ADDR_T1HI, 8'h80);
    wr(`DTC_ADDR_T1LO, 8'hF8);
    wr(`DTC_ADDR_T0HI, 8'hF0);
    wr(`DTC_ADDR_CTRL, 8'h40);
    waitOvf(1);
    `CHK("tf1 split", 1'b1, irqReq[3])
    `CHK("tf0 split", 1'b0, irqReq[1])
    wr(`DTC_ADDR_CTRL, 8'h01);
    chkRd(`DTC_ADDR_T0HI, 8'h02);
    chkRd(`DTC_ADDR_T1LO, 8'h8A);
    chkRd(`DTC_ADDR_T1HI, 8'h80);
    // Timer 1 counts pin edges only while its gate pin is high
    wr(`DTC_ADDR_MODE, 8'hD0);
    wr(`DTC_ADDR_T1LO, 8'h00);
    wr(`DTC_ADDR_T1HI, 8'h00);
    extIrqPinB = 1'b0;
    wr(`DTC_ADDR_CTRL, 8'h40);
    src1_u.pulses(2);
    extIrqPinB = 1'b1;
    src1_u.pulses(3);
    repeat (6) @(negedge clk);
    wr(`DTC_ADDR_CTRL, 8'h01);
    chkRd(`DTC_ADDR_T1LO, 8'h03);
    // Edge-triggered interrupt 1
    wr(`DTC_ADDR_CTRL, 8'h04);
    extIrqPinB = 1'b0;
    repeat (5) @(negedge clk);
    `CHK("ie1", 1'b1, irqReq[2])
    ack(2);
    `CHK("ie1 clr", 1'b0, irqReq[2])
    // Level-triggered interrupt 0 follows the pin
    extIrqPinA = 1'b0;
    repeat (5) @(negedge clk);
    `CHK("ie0", 1'b1, irqReq[0])
    ack(0);
    `CHK("ie0 level", 1'b1, irqReq[0])
    extIrqPinA = 1'b1;
    repeat (5) @(negedge clk);
    `CHK("ie0 gone", 1'b0, irqReq[0])
    report_and_stop();
  end
endmodule : dtc_timer_tb
